/* rtl/seamq_pkg.sv */
package seamq_pkg;

  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int SET_N    = 4;     // Register sets
  localparam int DATA_W   = 16;    // Mask and answer width
  localparam int CODE_W   = 11;    // Signed message code width
  localparam int FILT_N   = 2048;  // One filter bit per code
  localparam int OQ_DEPTH = 8;     // Response queue entries
  localparam int EQ_DEPTH = 10;    // Error queue entries

  // ----------------------------------------------------------
  // Set indices, status byte bits, masks
  // ----------------------------------------------------------
  localparam logic [1:0] SEL_STD  = 2'h0;
  localparam logic [1:0] SEL_OPER = 2'h1;
  localparam logic [1:0] SEL_MEAS = 2'h2;
  localparam logic [1:0] SEL_QUES = 2'h3;
  localparam int SB_MEAS = 0;
  localparam int SB_EAV  = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV  = 4;
  localparam int SB_ESB  = 5;
  localparam int SB_OPER = 7;
  localparam int MASK_TOP = 15;               // Never settable
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [15:0] STD_FIELD = 16'h00FF;
  localparam logic [15:0] WIDE_FIELD = 16'hFFFF;

  // ----------------------------------------------------------
  // Message codes (11-bit two's complement)
  // ----------------------------------------------------------
  localparam logic [10:0] CODE_RANGE = 11'h722; // -222
  localparam logic [10:0] CODE_OVF   = 11'h15E; // 350
  localparam logic [10:0] CODE_NONE  = 11'h000; // 0
  localparam logic [10:0] STAT_LO    = 11'h064; // Status 100
  localparam logic [10:0] STAT_HI    = 11'h18F; // Status 399

  // ----------------------------------------------------------
  // Commands
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_MASK_WR   = 4'h1,
    OP_MASK_RD   = 4'h2,
    OP_EVENT_RD  = 4'h3,
    OP_PRESET    = 4'h4,
    OP_CLS       = 4'h5,
    OP_QCLR      = 4'h6,
    OP_FLT_START = 4'h7,
    OP_FLT_EN    = 4'h8,
    OP_FLT_DIS   = 4'h9,
    OP_FLT_RD    = 4'hA,
    OP_ERR_RD    = 4'hB
  } seamq_op_e;

  typedef struct packed {
    seamq_op_e   op;    // What to do
    logic [1:0]  sel;   // Register set or filter view
    logic [15:0] data;  // Mask value
    logic [10:0] lo;    // Code or range end
    logic [10:0] hi;    // Other range end
  } seamq_cmd_s;

  typedef logic [SET_N-1:0][15:0] seamq_sets_t;

endpackage

/* rtl/seamq_resp_fifo.sv */
module seamq_resp_fifo import seamq_pkg::*; (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        push,
  input  wire logic [15:0] push_data,
  input  wire logic        pop,
  output logic      [15:0] head,
  output logic      [3:0]  count
);
  // ----------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------
  logic [15:0] mem [OQ_DEPTH];  // Entries
  logic [2:0]  rd_reg;          // Oldest entry
  logic [2:0]  wr_reg;          // Next free slot
  logic        do_push;
  logic        do_pop;

  assign do_pop  = pop && (count != 4'h0);
  assign do_push = push && ((count != 4'h8) || do_pop);
  assign head    = (count != 4'h0) ? mem[rd_reg] : 16'h0000;

  // Pointer and count update, oldest leaves first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_reg <= 3'h0;
      wr_reg <= 3'h0;
      count  <= 4'h0;
    end else if (ce) begin
      if (do_pop) rd_reg <= rd_reg + 3'h1;
      if (do_push) wr_reg <= wr_reg + 3'h1;
      count <= count + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

  // Entry write
  always_ff @(posedge clock) begin
    if (ce && do_push) mem[wr_reg] <= push_data;
  end
endmodule

/* rtl/seamq_err_queue.sv */
module seamq_err_queue import seamq_pkg::*; (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        clr,
  input  wire logic        push,
  input  wire logic [10:0] push_code,
  input  wire logic        pop,
  output logic      [10:0] head,
  output logic      [3:0]  count
);
  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------
  logic [10:0] mem [EQ_DEPTH];       // Signed codes
  logic [3:0]  rd_reg, wr_reg;       // Ring pointers
  logic [3:0]  rd_b, wr_b, cnt_b;    // After optional clear
  logic        do_push, do_pop;
  logic [10:0] slot;                 // Code stored this cycle

  function automatic logic [3:0] inc(input logic [3:0] p);
    return (p == 4'h9) ? 4'h0 : p + 4'h1;
  endfunction

  // Clear first, then a same-cycle push still lands
  always_comb begin
    rd_b    = clr ? 4'h0 : rd_reg;
    wr_b    = clr ? 4'h0 : wr_reg;
    cnt_b   = clr ? 4'h0 : count;
    do_pop  = pop && !clr && (count != 4'h0);
    do_push = push && (cnt_b != 4'hA);
    slot    = ((cnt_b == 4'h9) && !do_pop) ? CODE_OVF
                                           : push_code;
  end

  // Empty queue answers with code 0
  assign head = (count != 4'h0) ? mem[rd_reg] : CODE_NONE;

  // Pointers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_reg <= 4'h0;
      wr_reg <= 4'h0;
      count  <= 4'h0;
    end else if (ce) begin
      rd_reg <= do_pop ? inc(rd_b) : rd_b;
      wr_reg <= do_push ? inc(wr_b) : wr_b;
      count  <= cnt_b + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

  // Entry write
  always_ff @(posedge clock) begin
    if (ce && do_push) mem[wr_b] <= slot;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_queue_depth: assert property (
    count <= 4'hA) else $error("error queue above ten");
  a_overflow_last: assert property (
    ce && do_push && (cnt_b == 4'h9) && !do_pop
    |=> (count == 4'hA) && (mem[(wr_reg == 4'h0) ? 4'h9
                                : wr_reg - 4'h1] == CODE_OVF))
    else $error("last slot not overflow code");
endmodule

/* rtl/seamq_top.sv */
module seamq_top import seamq_pkg::*; (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        cmd_valid,
  input  wire seamq_cmd_s  cmd,
  input  wire seamq_sets_t ev_in,
  input  wire logic        err_valid,
  input  wire logic [10:0] err_code,
  input  wire logic        talk_req,
  output logic      [15:0] talk_data_reg,
  output logic             talk_valid_reg,
  output logic      [7:0]  status_byte_reg,
  output logic      [3:0]  sum_reg
);

  // ----------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------

  // Command of a given kind taken this cycle
  function automatic logic hit(input seamq_cmd_s c,
                               input logic v,
                               input seamq_op_e o);
    return v && (c.op == o);
  endfunction

  // Filter index of a signed code, offset by half range
  function automatic logic [10:0] idx_of(input logic [10:0] c);
    return {~c[10], c[9:0]};
  endfunction

  // Signed inclusive range test, ends in any order
  function automatic logic in_range(input logic [10:0] i,
                                    input logic [10:0] a,
                                    input logic [10:0] b);
    logic signed [10:0] c, mn, mx;
    c  = signed'({~i[10], i[9:0]});
    mn = ($signed(a) < $signed(b)) ? $signed(a) : $signed(b);
    mx = ($signed(a) < $signed(b)) ? $signed(b) : $signed(a);
    return (c >= mn) && (c <= mx);
  endfunction

  // Power-up filter: errors on, status band off
  function automatic logic flt_default(input logic [10:0] i);
    return !in_range(i, STAT_LO, STAT_HI);
  endfunction

  // Implemented field of each set
  function automatic logic [15:0] field(input int s);
    return (s == 0) ? STD_FIELD : WIDE_FIELD;
  endfunction

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [15:0]       mask_reg [SET_N];  // Enable masks
  logic [15:0]       ev_reg [SET_N];    // Latched events
  logic [FILT_N-1:0] filt_reg;          // Enabled codes
  logic              rej_pend_reg;      // Range error waiting

  // ----------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------
  logic        take;          // Command accepted
  logic        mask_wr;       // Mask write request
  logic        mask_bad;      // Out-of-range mask value
  logic        preset, cls;   // Preset, clear-status
  logic        flt_bit;       // Queried code is enabled
  logic        ext_push;      // Outside error admitted
  logic        rej_push;      // Range error admitted
  logic        eq_push;       // Error queue push
  logic [10:0] eq_code;       // Code pushed
  logic        eq_pop;        // Error queue read
  logic [10:0] eq_head;       // Oldest error code
  logic [3:0]  eq_cnt;        // Error queue fill
  logic        oq_push;       // Response queue push
  logic [15:0] oq_data;       // Response pushed
  logic [15:0] oq_head;       // Oldest response
  logic [3:0]  oq_cnt;        // Response queue fill
  logic [3:0]  sum_next;      // Summaries from current state

  assign take    = ce && cmd_valid;
  assign mask_wr = hit(cmd, take, OP_MASK_WR);
  assign preset  = hit(cmd, take, OP_PRESET);
  assign cls     = hit(cmd, take, OP_CLS);

  // Reject top bit, and anything above a byte for standard set
  always_comb begin
    if (cmd.sel == SEL_STD) mask_bad = (cmd.data & ~STD_FIELD)
                                       != 16'h0000;
    else mask_bad = cmd.data[MASK_TOP];
    mask_bad = mask_bad && mask_wr;
  end

  // ----------------------------------------------------------
  // Enable masks
  // ----------------------------------------------------------

  // Clear on reset and preset; clear-status leaves them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int s = 0; s < SET_N; s++)
        mask_reg[s] <= MASK_RST;
    end else if (ce) begin
      for (int s = 0; s < SET_N; s++) begin
        if (preset) mask_reg[s] <= MASK_RST;
        else if (mask_wr && !mask_bad &&
                 (cmd.sel == 2'(s)))
          mask_reg[s] <= cmd.data;
      end
    end
  end

  // ----------------------------------------------------------
  // Latched events
  // ----------------------------------------------------------

  // New event wins over the read or clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int s = 0; s < SET_N; s++)
        ev_reg[s] <= 16'h0000;
    end else if (ce) begin
      for (int s = 0; s < SET_N; s++) begin
        if (cls || (hit(cmd, take, OP_EVENT_RD) &&
                    (cmd.sel == 2'(s))))
          ev_reg[s] <= ev_in[s] & field(s);
        else
          ev_reg[s] <= (ev_reg[s] | ev_in[s]) & field(s);
      end
    end
  end

  // ----------------------------------------------------------
  // Summaries and status byte
  // ----------------------------------------------------------

  // AND each set with its mask, OR the result
  always_comb begin
    for (int s = 0; s < SET_N; s++)
      sum_next[s] = |(ev_reg[s] & mask_reg[s]);
  end

  // Registered every cycle from current contents
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sum_reg         <= 4'h0;
      status_byte_reg <= 8'h00;
    end else if (ce) begin
      sum_reg                  <= sum_next;
      status_byte_reg          <= 8'h00;
      status_byte_reg[SB_ESB]  <= sum_next[SEL_STD];
      status_byte_reg[SB_OPER] <= sum_next[SEL_OPER];
      status_byte_reg[SB_MEAS] <= sum_next[SEL_MEAS];
      status_byte_reg[SB_QUES] <= sum_next[SEL_QUES];
      status_byte_reg[SB_MAV]  <= oq_cnt != 4'h0;
      status_byte_reg[SB_EAV]  <= eq_cnt != 4'h0;
    end
  end

  // ----------------------------------------------------------
  // Code filter
  // ----------------------------------------------------------

  // Defaults only at reset; start clears, enable adds, disable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < FILT_N; i++)
        filt_reg[i] <= flt_default(11'(i));
    end else if (ce) begin
      for (int i = 0; i < FILT_N; i++) begin
        if (hit(cmd, take, OP_FLT_START))
          filt_reg[i] <= 1'b0;
        else if (hit(cmd, take, OP_FLT_EN) &&
                 in_range(11'(i), cmd.lo, cmd.hi))
          filt_reg[i] <= 1'b1;
        else if (hit(cmd, take, OP_FLT_DIS) &&
                 in_range(11'(i), cmd.lo, cmd.hi))
          filt_reg[i] <= 1'b0;
      end
    end
  end

  assign flt_bit = filt_reg[idx_of(cmd.lo)];

  // ----------------------------------------------------------
  // Error queue feed
  // ----------------------------------------------------------

  // Outside error first; range error waits for a free cycle
  assign ext_push = ce && err_valid &&
                    filt_reg[idx_of(err_code)];
  assign rej_push = rej_pend_reg && !ext_push &&
                    filt_reg[idx_of(CODE_RANGE)];
  assign eq_push  = ext_push || rej_push;
  assign eq_code  = ext_push ? err_code : CODE_RANGE;
  assign eq_pop   = hit(cmd, take, OP_ERR_RD);

  // Pending range error, set wins over drain
  always_ff @(posedge clock) begin
    if (sys_rst) rej_pend_reg <= 1'b0;
    else if (ce)
      rej_pend_reg <= mask_bad ||
                      (rej_pend_reg && ext_push);
  end

  seamq_err_queue u_err_queue (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .clr       (cls || hit(cmd, take, OP_QCLR)),
    .push      (eq_push),
    .push_code (eq_code),
    .pop       (eq_pop),
    .head      (eq_head),
    .count     (eq_cnt)
  );

  // ----------------------------------------------------------
  // Response queue
  // ----------------------------------------------------------

  // Query answers enter the response queue, dropped when it is full with no pop that cycle
  always_comb begin
    oq_push = take;
    oq_data = 16'h0000;
    case (cmd.op)
      OP_MASK_RD:  oq_data = mask_reg[cmd.sel];
      OP_EVENT_RD: oq_data = ev_reg[cmd.sel];
      OP_FLT_RD:   oq_data = {15'h0000,
                      flt_bit ^ (cmd.sel != 2'h0)};
      OP_ERR_RD:   oq_data = {{5{eq_head[10]}}, eq_head};
      default:     oq_push = 1'b0;
    endcase
  end

  seamq_resp_fifo u_resp_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .push      (oq_push),
    .push_data (oq_data),
    .pop       (ce && talk_req),
    .head      (oq_head),
    .count     (oq_cnt)
  );

  // Talk: hand out the oldest answer, one-cycle strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      talk_data_reg  <= 16'h0000;
      talk_valid_reg <= 1'b0;
    end else if (ce) begin
      talk_valid_reg <= talk_req;
      if (talk_req) talk_data_reg <= oq_head;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_bad_write;
    ce && cmd_valid && cmd.op == OP_MASK_WR &&
    cmd.sel != SEL_STD && cmd.data[MASK_TOP];
  endsequence

  a_top_bit_clear: assert property (
    !mask_reg[1][MASK_TOP] && !mask_reg[2][MASK_TOP] &&
    !mask_reg[3][MASK_TOP]) else $error("mask bit 15 set");
  a_bad_write_held: assert property (
    s_bad_write |=> $stable(mask_reg[1]) && $stable(mask_reg[2]) &&
    $stable(mask_reg[3]) && rej_pend_reg)
    else $error("bad mask write not rejected");
  a_std_byte_only: assert property (
    mask_reg[0][15:8] == 8'h00) else $error("std mask too wide");
  a_mask_write: assert property (
    mask_wr && !mask_bad |=> mask_reg[$past(cmd.sel)] ==
    $past(cmd.data)) else $error("mask write lost");
  a_preset_clears: assert property (
    preset |=> mask_reg[0] == 16'h0000 && mask_reg[1] == 16'h0000
    && mask_reg[2] == 16'h0000 && mask_reg[3] == 16'h0000)
    else $error("preset left mask set");
  a_cls_keeps: assert property (
    cls && !preset |=> $stable(mask_reg[1]) && $stable(filt_reg))
    else $error("clear-status changed mask or filter");
  a_summary_and: assert property (
    ce |=> status_byte_reg[SB_OPER] ==
    $past(|(ev_reg[1] & mask_reg[1]))) else $error("bad summary");
  a_mav_flag: assert property (
    ce |=> status_byte_reg[SB_MAV] == ($past(oq_cnt) != 4'h0))
    else $error("message flag wrong");
  a_eav_flag: assert property (
    ce |=> status_byte_reg[SB_EAV] == ($past(eq_cnt) != 4'h0))
    else $error("error flag wrong");
  a_empty_list: assert property (
    hit(cmd, take, OP_FLT_START) |=> filt_reg == '0)
    else $error("empty list left codes enabled");
  a_talk_strobe: assert property (
    ce && talk_req |=> talk_valid_reg)
    else $error("talk strobe missing");

  // Read of the operation set with no new event arriving
  sequence s_oper_read;
    hit(cmd, take, OP_EVENT_RD) && cmd.sel == SEL_OPER &&
    ev_in[SEL_OPER] == 16'h0000;
  endsequence

  // Either queue clear with no push in the same cycle
  sequence s_queue_clear;
    (cls || hit(cmd, take, OP_QCLR)) && !eq_push;
  endsequence

  // Latched bits survive until the set is read or cleared
  a_event_held: assert property (
    ce && !cls && !(hit(cmd, take, OP_EVENT_RD) && cmd.sel == SEL_OPER)
    |=> (ev_reg[1] & $past(ev_reg[1])) == $past(ev_reg[1]))
    else $error("latched event lost");

  // A read with no new event leaves the set empty
  a_event_cleared: assert property (
    s_oper_read |=> ev_reg[1] == 16'h0000)
    else $error("event read did not clear");

  // Clear-status or queue clear empties the error queue
  a_queue_emptied: assert property (
    s_queue_clear |=> eq_cnt == 4'h0)
    else $error("error queue not emptied");

  // Power-up filter: status band off, standard errors on
  a_filter_reset: assert property (
    $fell(sys_rst) |-> !filt_reg[idx_of(STAT_LO)] &&
    filt_reg[idx_of(CODE_RANGE)]) else $error("filter default wrong");

  // Preset leaves the code filter alone
  a_preset_filter: assert property (
    preset |=> $stable(filt_reg)) else $error("preset changed filter");

  // Measurement and questionable summaries follow their masks
  a_summary_other: assert property (
    ce |=> sum_reg[SEL_MEAS] == $past(|(ev_reg[2] & mask_reg[2])) &&
    sum_reg[SEL_QUES] == $past(|(ev_reg[3] & mask_reg[3])))
    else $error("summary not recomputed");
endmodule

/* test/seamq_host.sv */
// Host model: polls the message flag, addresses the device to talk
module seamq_host (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic auto_read,
  input  wire logic msg_flag,
  output logic      talk_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_reg;  // Spacing until the flag has settled

  // One talk pulse, then wait for the flag to update
  always @(negedge clock) begin
    talk_req <= 1'b0;
    if (sys_rst) begin
      wait_reg <= 3'h0;
    end else if (wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
    end else if (auto_read && msg_flag) begin
      talk_req <= 1'b1;
      wait_reg <= 3'h3;
    end
  end
endmodule

/* test/seamq_tb.sv */
module seamq_tb import seamq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock     = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        ce        = 1'b1;
  logic        cmd_valid = 1'b0;
  seamq_cmd_s  cmd       = '0;
  seamq_sets_t ev_in     = '0;
  logic        err_valid = 1'b0;
  logic [10:0] err_code  = 11'h000;
  logic        auto_read = 1'b0;
  logic        talk_req;
  logic [15:0] talk_data_reg;
  logic        talk_valid_reg;
  logic [7:0]  status_byte_reg;
  logic [3:0]  sum_reg;
  int          bad_count = 0;
  int          tests_run = 0;
  integer      seed      = 43717;
  logic [15:0] exp_q[$];   // Expected talk words, oldest first
  logic [15:0] mx[4];      // Mask values last written
  logic [15:0] v;
  int          sbp[4] = '{SB_ESB, SB_OPER, SB_MEAS, SB_QUES};

  always #5 clock = ~clock;

  seamq_top dut (.clock(clock), .sys_rst(sys_rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .ev_in(ev_in),
    .err_valid(err_valid), .err_code(err_code), .talk_req(talk_req),
    .talk_data_reg(talk_data_reg), .talk_valid_reg(talk_valid_reg),
    .status_byte_reg(status_byte_reg), .sum_reg(sum_reg));

  seamq_host host (.clock(clock), .sys_rst(sys_rst),
    .auto_read(auto_read), .msg_flag(status_byte_reg[SB_MAV]),
    .talk_req(talk_req));

  // ----------------------------------------------------------
  // Compare, drive and report tasks
  // ----------------------------------------------------------
  task automatic chk_word(input string n, input logic [15:0] e,
                          input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  // One command, then room for the host to drain
  task automatic do_cmd(input seamq_op_e o, input logic [1:0] s,
                        input logic [15:0] d, input logic [10:0] l,
                        input logic [10:0] h);
    cmd.op = o;
    cmd.sel = s;
    cmd.data = d;
    cmd.lo = l;
    cmd.hi = h;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    repeat (5) @(negedge clock);
  endtask

  // Query with its expected answer noted first
  task automatic query(input seamq_op_e o, input logic [1:0] s,
                       input logic [10:0] l, input logic [15:0] e);
    exp_q.push_back(e);
    do_cmd(o, s, 16'h0000, l, l);
  endtask

  task automatic err(input logic [10:0] c);
    err_code = c;
    err_valid = 1'b1;
    @(negedge clock);
    err_valid = 1'b0;
    @(negedge clock);
  endtask

  function automatic logic [15:0] sx(input logic [10:0] c);
    return {{5{c[10]}}, c};
  endfunction

  task automatic done_test(input string n);
    $display("test %s done, mismatches %0d", n, bad_count);
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Monitor: every talk word against the oldest note
  always @(negedge clock) begin
    logic [15:0] e;
    if (talk_valid_reg === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
      chk_word("talk", e, talk_data_reg);
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize;
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    chk_word("status", 16'h0000, {8'h00, status_byte_reg});
    for (int s = 0; s < 4; s++)
      query(OP_MASK_RD, 2'(s), 11'h000, 16'h0000);
    chk_bit("msg", 1'b1, status_byte_reg[SB_MAV]);
    auto_read = 1'b1;
    repeat (20) @(negedge clock);
    chk_bit("msg", 1'b0, status_byte_reg[SB_MAV]);
    done_test("reset");
    // Random and top values, then two refused writes
    for (int k = 0; k < 2; k++)
      for (int s = 0; s < 4; s++) begin
        v = $random(seed);
        if (k == 1) v = 16'hFFFF;
        v = (s == 0) ? (v & STD_FIELD) : (v & 16'h7FFF);
        mx[s] = v;
        do_cmd(OP_MASK_WR, 2'(s), v, 11'h000, 11'h000);
        query(OP_MASK_RD, 2'(s), 11'h000, v);
      end
    do_cmd(OP_MASK_WR, SEL_STD, 16'h0100, 11'h000, 11'h000);
    do_cmd(OP_MASK_WR, SEL_OPER, 16'h8001, 11'h000, 11'h000);
    chk_bit("err", 1'b1, status_byte_reg[SB_EAV]);
    query(OP_MASK_RD, SEL_STD, 11'h000, mx[0]);
    query(OP_MASK_RD, SEL_OPER, 11'h000, mx[1]);
    query(OP_ERR_RD, SEL_STD, 11'h000, sx(CODE_RANGE));
    query(OP_ERR_RD, SEL_STD, 11'h000, sx(CODE_RANGE));
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h0000);
    chk_bit("err", 1'b0, status_byte_reg[SB_EAV]);
    done_test("masks");
    // Clear-status keeps masks, preset zeroes them
    for (int k = 0; k < 2; k++) begin
      do_cmd(k ? OP_PRESET : OP_CLS, SEL_STD, 16'h0000, 11'h000, 11'h000);
      for (int s = 0; s < 4; s++)
        query(OP_MASK_RD, 2'(s), 11'h000, k ? 16'h0000 : mx[s]);
    end
    done_test("preset");
    // Latched event through mask to summary, per set
    for (int s = 0; s < 4; s++) begin
      v = 16'h0001 << (s + 1);
      do_cmd(OP_MASK_WR, 2'(s), v, 11'h000, 11'h000);
      ev_in[s] = v;
      @(negedge clock);
      ev_in[s] = 16'h0000;
      repeat (3) @(negedge clock);
      chk_bit("sum", 1'b1, sum_reg[s]);
      chk_bit("sb", 1'b1, status_byte_reg[sbp[s]]);
      do_cmd(OP_MASK_WR, 2'(s), 16'h0000, 11'h000, 11'h000);
      chk_bit("sum", 1'b0, sum_reg[s]);
      do_cmd(OP_MASK_WR, 2'(s), v, 11'h000, 11'h000);
      chk_bit("sum", 1'b1, sum_reg[s]);
      query(OP_EVENT_RD, 2'(s), 11'h000, v);
      chk_bit("sum", 1'b0, sum_reg[s]);
    end
    done_test("summary");
    // Twelve errors into a ten-deep queue
    for (int i = 0; i < 12; i++)
      err(11'h700 + 11'(i));
    chk_bit("err", 1'b1, status_byte_reg[SB_EAV]);
    for (int i = 0; i < 9; i++)
      query(OP_ERR_RD, SEL_STD, 11'h000,
            sx(11'h700 + 11'(i)));
    query(OP_ERR_RD, SEL_STD, 11'h000, sx(CODE_OVF));
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h0000);
    done_test("overflow");
    // Code filter
    err(11'h0C8);
    err(11'h792);
    query(OP_ERR_RD, SEL_STD, 11'h000, sx(11'h792));
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h0000);
    do_cmd(OP_FLT_START, SEL_STD, 16'h0000, 11'h000, 11'h000);
    err(11'h792);
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h0000);
    do_cmd(OP_FLT_EN, SEL_STD, 16'h0000, 11'h0CD, 11'h0C8);
    do_cmd(OP_FLT_DIS, SEL_STD, 16'h0000, 11'h0CA, 11'h0CA);
    err(11'h0CA);
    err(11'h0C9);
    err(11'h792);
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h00C9);
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h0000);
    query(OP_FLT_RD, 2'h0, 11'h0C9, 16'h0001);
    query(OP_FLT_RD, 2'h1, 11'h0CA, 16'h0001);
    err(11'h0C9);
    do_cmd(OP_QCLR, SEL_STD, 16'h0000, 11'h000, 11'h000);
    chk_bit("err", 1'b0, status_byte_reg[SB_EAV]);
    err(11'h0CB);
    do_cmd(OP_CLS, SEL_STD, 16'h0000, 11'h000, 11'h000);
    chk_bit("err", 1'b0, status_byte_reg[SB_EAV]);
    do_cmd(OP_PRESET, SEL_STD, 16'h0000, 11'h000, 11'h000);
    err(11'h0C9);
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h00C9);
    done_test("filter");
    // Clock enable low freezes queue and masks
    ce = 1'b0;
    err(11'h792);
    do_cmd(OP_MASK_WR, SEL_OPER, 16'h0005, 11'h000, 11'h000);
    ce = 1'b1;
    chk_bit("err", 1'b0, status_byte_reg[SB_EAV]);
    query(OP_MASK_RD, SEL_OPER, 11'h000, 16'h0000);
    // Second reset restores filter defaults
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    err(11'h0C9);
    err(11'h792);
    query(OP_ERR_RD, SEL_STD, 11'h000, sx(11'h792));
    query(OP_ERR_RD, SEL_STD, 11'h000, 16'h0000);
    // Nine queries into the eight-deep response queue
    auto_read = 1'b0;
    for (int i = 0; i < 8; i++)
      query(OP_FLT_RD, 2'h0, 11'h18C + 11'(i), {15'h0000, (i > 3)});
    do_cmd(OP_FLT_RD, 2'h0, 16'h0000, 11'h000, 11'h000);
    auto_read = 1'b1;
    repeat (40) @(negedge clock);
    repeat (10) @(negedge clock);
    chk_word("left", 16'h0000, 16'(exp_q.size()));
    done_test("rereset");
    summarize;
  end
endmodule
